// ### design/sceic_cfg.svh
`ifndef SCEIC_CFG_SVH
`define SCEIC_CFG_SVH
// ==========================================
// register indices (byte address = index * 4)
`define SCEIC_EIC_IDX 8'h1a
`define SCEIC_CFG_IDX 8'h10
`define SCEIC_MODE_IDX 8'h11
// ==========================================
// reset values
`define SCEIC_EIC_RST 8'h04
`define SCEIC_CFG_RST 8'h30
// ==========================================
// interrupt control/status bit positions
`define SCEIC_B_KFLAG 7
`define SCEIC_B_KSCAN 6
`define SCEIC_B_KACK 5
`define SCEIC_B_KEDGE 4
`define SCEIC_B_IFLAG 3
`define SCEIC_B_IEN 2
`define SCEIC_B_IACK 1
`define SCEIC_B_IEL 0
// ==========================================
// configuration bit positions
`define SCEIC_B_WDE 0
`define SCEIC_B_IV 1
`define SCEIC_B_FMV 2
`define SCEIC_B_LVRE 3
`define SCEIC_B_S1LO 4
`define SCEIC_B_S1HI 5
// ==========================================
// select-one codes
`define SCEIC_S1_P0 2'b00
`define SCEIC_S1_P0STR 2'b01
`define SCEIC_S1_GP 2'b10
`define SCEIC_S1_PORT 2'b11
// ==========================================
// address windows
`define SCEIC_PAGE0_END 16'h00ff
`define SCEIC_GP_LO 16'h4000
`define SCEIC_GP_HI 16'h7fff
`define SCEIC_STR_LO 16'h0030
`define SCEIC_STR_HI 16'h003f
// ==========================================
// timing: oscillator clocks per bus cycle, stretched hold length
`define SCEIC_BUS_PHASES 4
`define SCEIC_STRETCH_CYC 10
`endif

// ### design/sceic_pkg.sv
package sceic_pkg;
	// ==========================================
	// bus-cycle phases
	typedef enum logic [2:0] {
		BS_IDLE,
		BS_ADDR,
		BS_STRB,
		BS_HOLD,
		BS_END
	} sceic_phase_t;

	// apb request from the master
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} sceic_apb_req_t;

	// cpu access request
	typedef struct packed {
		logic valid;
		logic write;
		logic internalAcc;
		logic fetch;
		logic [15:0] addr;
		logic [7:0] wdata;
	} sceic_cpu_req_t;

	// expanded bus pins, outputs only
	typedef struct packed {
		logic [7:0] addrHi;
		logic [7:0] addrLo;
		logic [7:0] adOut;
		logic adOeN;
		logic rdN;
		logic wrN;
		logic addrStrobe;
		logic selectOneN;
		logic selectTwoN;
		logic a15SelN;
		logic fetchMarkN;
	} sceic_ext_t;
endpackage

// ### design/sys_config_ext_int_ctrl.sv
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`include "sceic_cfg.svh"

module sys_config_ext_int_ctrl #(
	parameter int STRETCH_CYC = `SCEIC_STRETCH_CYC
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire sceic_pkg::sceic_apb_req_t apbReq,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire sceic_pkg::sceic_cpu_req_t cpuReq,
	output logic cpuReady,
	output logic [7:0] cpuRdata,
	input wire logic vectorFetch,
	input wire logic stopWaitExec,
	output sceic_pkg::sceic_ext_t extBus,
	input wire logic [7:0] adIn,
	input wire logic modeIn,
	output logic modeOut,
	output logic modeOeN,
	input wire logic extIntN,
	input wire logic [7:0] portDIn,
	input wire logic [7:0] portDDir,
	output logic selectOneIsPort,
	output logic irqReq,
	output logic kbdIrqReq,
	output logic wakeReq,
	output logic watchdogEnable,
	output logic lowVoltageResetEnable,
	output logic busMuxed
);
	// ==========================================
	// elaboration checks
	generate
		if (STRETCH_CYC < 1 || STRETCH_CYC > 255) begin : g_bad_stretch
			$error("STRETCH_CYC must lie in 1..255");
		end
	endgenerate

	localparam logic [7:0] STR_LOAD = 8'(STRETCH_CYC - 1);
	localparam int STR_DLY = STRETCH_CYC + 3;

	typedef struct packed {
		logic [7:0] cfg;
		logic wdLock;
		logic kEdgeLock;
		logic ielLock;
		logic kScan;
		logic kEdge;
		logic kFlag;
		logic kLatch;
		logic kPrev;
		logic iEn;
		logic iel;
		logic iFlag;
		logic iLatch;
		logic iPrev;
		logic inReset;
		logic muxed;
		sceic_pkg::sceic_phase_t phase;
		logic [7:0] cnt;
		logic vis;
		logic wr;
		sceic_pkg::sceic_ext_t ext;
		logic [7:0] lastData;
		logic [7:0] rdData;
		logic [31:0] prdata;
		logic slvErr;
	} sceic_state_t;

	sceic_state_t st_r;
	sceic_state_t st_nxt;

	// ==========================================
	// helpers
	function automatic logic regHit(input logic [11:0] a, input logic [7:0] idx);
		regHit = (a == {2'b00, idx, 2'b00});
	endfunction

	function automatic logic inRange(input logic [15:0] a, input logic [15:0] lo,
			input logic [15:0] hi);
		inRange = (a >= lo) && (a <= hi);
	endfunction

	logic setupPh;
	logic wrCfg;
	logic wrEic;
	logic [7:0] wd;
	logic iFall;
	logic iSet;
	logic kLow;
	logic kFall;
	logic kSet;
	logic accept;
	logic visNow;
	logic strMatch;
	logic [1:0] s1c;
	logic [7:0] eicRd;

	// apb decode; writes land at the access edge where pready is seen high, read
	// data is registered at the setup edge so the access phase needs no wait
	assign setupPh = apbReq.psel && !apbReq.penable;
	assign wd = apbReq.pwdata[7:0];
	assign wrCfg = pready && apbReq.pwrite && regHit(apbReq.paddr, `SCEIC_CFG_IDX);
	assign wrEic = pready && apbReq.pwrite && regHit(apbReq.paddr, `SCEIC_EIC_IDX);
	assign s1c = st_r.cfg[`SCEIC_B_S1HI:`SCEIC_B_S1LO];

	// interrupt pin edge and level terms
	assign iFall = st_r.iPrev && !extIntN;
	assign iSet = iFall || (st_r.iel && !extIntN);
	// keyboard: any input-configured port d line low, only while enabled
	assign kLow = st_r.kScan && |(~portDIn & ~portDDir);
	assign kFall = kLow && !st_r.kPrev;
	assign kSet = kFall || (st_r.kEdge && kLow);

	// bus access request decode
	assign accept = (st_r.phase == sceic_pkg::BS_IDLE) && cpuReq.valid;
	assign visNow = !cpuReq.internalAcc || st_r.cfg[`SCEIC_B_IV];
	assign strMatch = (s1c == `SCEIC_S1_P0STR)
		&& inRange(cpuReq.addr, `SCEIC_STR_LO, `SCEIC_STR_HI);

	assign eicRd = {st_r.kFlag, st_r.kScan, 1'b0, st_r.kEdge,
		st_r.iFlag, st_r.iEn, 1'b0, st_r.iel};

	// ==========================================
	// next-state logic
	always_comb begin
		st_nxt = st_r;

		// bus mode is caught once, on the first edge after reset release
		if (st_r.inReset) begin
			st_nxt.inReset = 1'b0;
			st_nxt.muxed = modeIn;
		end

		// configuration register; watchdog bit locks after one write
		if (wrCfg) begin
			st_nxt.cfg[7:1] = wd[7:1];
			if (!st_r.wdLock) begin
				st_nxt.cfg[`SCEIC_B_WDE] = wd[`SCEIC_B_WDE];
				st_nxt.wdLock = 1'b1;
			end
		end

		// control/status register writes; flag bits are read-only
		if (wrEic) begin
			st_nxt.kScan = wd[`SCEIC_B_KSCAN];
			st_nxt.iEn = wd[`SCEIC_B_IEN];
			if (!st_r.kEdgeLock) begin
				st_nxt.kEdge = wd[`SCEIC_B_KEDGE];
				st_nxt.kEdgeLock = 1'b1;
			end
			if (!st_r.ielLock) begin
				st_nxt.iel = wd[`SCEIC_B_IEL];
				st_nxt.ielLock = 1'b1;
			end
			if (wd[`SCEIC_B_KACK]) begin
				st_nxt.kLatch = 1'b0;
				if (!st_r.kEdge) begin
					st_nxt.kFlag = 1'b0;
				end
			end
			if (wd[`SCEIC_B_IACK]) begin
				st_nxt.iLatch = 1'b0;
				if (!st_r.iel) begin
					st_nxt.iFlag = 1'b0;
				end
			end
		end

		// stop/wait beats a software write so the pin can always wake the part
		if (stopWaitExec) begin
			st_nxt.iEn = 1'b1;
		end

		// vector fetch clears the external flag and latch
		if (vectorFetch) begin
			st_nxt.iFlag = 1'b0;
			st_nxt.iLatch = 1'b0;
		end

		// events are applied last: a set in the clearing cycle wins
		st_nxt.iPrev = extIntN;
		if (iFall) begin
			st_nxt.iLatch = 1'b1;
		end
		if (iSet) begin
			st_nxt.iFlag = 1'b1;
		end
		st_nxt.kPrev = kLow;
		if (kFall) begin
			st_nxt.kLatch = 1'b1;
		end
		if (kSet) begin
			st_nxt.kFlag = 1'b1;
		end
		if (!st_r.kScan) begin
			st_nxt.kFlag = st_nxt.kFlag && st_r.kFlag;
		end

		// apb read data and error answer, registered at the setup edge
		if (setupPh) begin
			st_nxt.slvErr = 1'b0;
			st_nxt.prdata = 32'h0000_0000;
			if (regHit(apbReq.paddr, `SCEIC_CFG_IDX)) begin
				st_nxt.prdata[7:0] = st_r.cfg;
			end else if (regHit(apbReq.paddr, `SCEIC_EIC_IDX)) begin
				st_nxt.prdata[7:0] = eicRd;
			end else if (regHit(apbReq.paddr, `SCEIC_MODE_IDX)) begin
				st_nxt.prdata[0] = st_r.muxed;
			end else begin
				st_nxt.slvErr = 1'b1;
			end
		end

		// expanded bus sequencer, four oscillator clocks per unstretched bus cycle
		unique case (st_r.phase)
			sceic_pkg::BS_IDLE: begin
				if (accept) begin
					st_nxt.phase = sceic_pkg::BS_ADDR;
					st_nxt.vis = visNow;
					st_nxt.wr = cpuReq.write;
					st_nxt.cnt = strMatch ? STR_LOAD : 8'h00;
					// internal access with visibility off: pins keep old values
					if (visNow) begin
						st_nxt.ext.addrHi = cpuReq.addr[15:8];
						st_nxt.ext.fetchMarkN = !cpuReq.fetch;
						st_nxt.ext.a15SelN = cpuReq.addr[15];
						if (st_r.muxed) begin
							st_nxt.ext.adOut = cpuReq.addr[7:0];
							st_nxt.ext.adOeN = 1'b0;
							st_nxt.ext.addrStrobe = 1'b1;
						end else begin
							st_nxt.ext.addrLo = cpuReq.addr[7:0];
						end
						// select one by configured type, port code leaves it off
						unique case (s1c)
							`SCEIC_S1_P0, `SCEIC_S1_P0STR: begin
								st_nxt.ext.selectOneN = !inRange(cpuReq.addr,
									16'h0000, `SCEIC_PAGE0_END);
							end
							`SCEIC_S1_GP: begin
								st_nxt.ext.selectOneN = !inRange(cpuReq.addr,
									`SCEIC_GP_LO, `SCEIC_GP_HI);
							end
							`SCEIC_S1_PORT: begin
								st_nxt.ext.selectOneN = 1'b1;
							end
						endcase
						st_nxt.ext.selectTwoN = st_r.muxed || !inRange(cpuReq.addr,
							`SCEIC_GP_LO, `SCEIC_GP_HI);
					end
				end
			end
			sceic_pkg::BS_ADDR: begin
				st_nxt.phase = sceic_pkg::BS_STRB;
				st_nxt.ext.addrStrobe = 1'b0;
				if (st_r.vis) begin
					st_nxt.ext.rdN = st_r.wr;
					st_nxt.ext.wrN = !st_r.wr;
					st_nxt.ext.adOut = st_r.wr ? cpuReq.wdata : st_r.ext.adOut;
					st_nxt.ext.adOeN = !st_r.wr;
				end
			end
			sceic_pkg::BS_STRB: begin
				st_nxt.phase = sceic_pkg::BS_HOLD;
			end
			sceic_pkg::BS_HOLD: begin
				// stretched accesses stay here for the full stretch count
				if (st_r.cnt == 8'h00) begin
					st_nxt.phase = sceic_pkg::BS_END;
				end else begin
					st_nxt.cnt = st_r.cnt - 8'h01;
				end
			end
			sceic_pkg::BS_END: begin
				st_nxt.phase = sceic_pkg::BS_IDLE;
				st_nxt.ext.rdN = 1'b1;
				st_nxt.ext.wrN = 1'b1;
				st_nxt.ext.selectOneN = 1'b1;
				st_nxt.ext.selectTwoN = 1'b1;
				st_nxt.rdData = adIn;
				if (st_r.vis) begin
					// pins then carry the last external data while idle
					st_nxt.lastData = st_r.wr ? st_r.ext.adOut : adIn;
					st_nxt.ext.adOut = st_r.wr ? st_r.ext.adOut : adIn;
					st_nxt.ext.adOeN = 1'b0;
				end
			end
		endcase
	end

	// ==========================================
	// state register
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st_r <= '0;
			st_r.cfg <= `SCEIC_CFG_RST;
			st_r.iEn <= ((`SCEIC_EIC_RST >> `SCEIC_B_IEN) & 8'h01) != 8'h00;
			st_r.iPrev <= 1'b1;
			st_r.inReset <= 1'b1;
			st_r.phase <= sceic_pkg::BS_IDLE;
			st_r.ext <= '1;
			st_r.ext.addrStrobe <= 1'b0;
			st_r.ext.adOut <= 8'h00;
			st_r.ext.addrHi <= 8'h00;
			st_r.ext.addrLo <= 8'h00;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ==========================================
	// outputs
	assign pready = apbReq.psel && apbReq.penable;
	assign prdata = st_r.prdata;
	assign pslverr = pready && st_r.slvErr;
	assign cpuReady = (st_r.phase == sceic_pkg::BS_END);
	assign cpuRdata = st_r.rdData;
	assign extBus = st_r.ext;
	// marker drives the shared pin only after the mode is caught
	assign modeOeN = !(st_r.cfg[`SCEIC_B_FMV] && st_r.cfg[`SCEIC_B_IV]
		&& !st_r.inReset);
	assign modeOut = st_r.ext.fetchMarkN;
	assign selectOneIsPort = (s1c == `SCEIC_S1_PORT);
	assign irqReq = st_r.iFlag && st_r.iEn;
	assign kbdIrqReq = st_r.kFlag && st_r.kScan;
	assign wakeReq = kbdIrqReq || irqReq;
	assign watchdogEnable = st_r.cfg[`SCEIC_B_WDE];
	assign lowVoltageResetEnable = st_r.cfg[`SCEIC_B_LVRE];
	assign busMuxed = st_r.muxed;

	// ==========================================
	// assertions
	sequence sAcceptPlain;
		accept && !strMatch;
	endsequence

	sequence sAcceptStr;
		accept && strMatch;
	endsequence

	AST_WDE_LOCK: assert property (@(posedge sys_clk) disable iff (rst)
		st_r.wdLock |=> $stable(watchdogEnable))
		else $error("watchdog enable changed after lock");
	AST_STROBE_QUIET: assert property (@(posedge sys_clk) disable iff (rst)
		(accept && !visNow) |=> (extBus.rdN && extBus.wrN) [*4])
		else $error("strobe active on hidden access");
	AST_ADDR_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
		(accept && !visNow) |=> $stable(extBus.addrHi) && $stable(extBus.addrLo))
		else $error("address moved on hidden access");
	AST_MARK_DRIVE: assert property (@(posedge sys_clk) disable iff (rst)
		!modeOeN |-> st_r.cfg[`SCEIC_B_FMV] && st_r.cfg[`SCEIC_B_IV])
		else $error("marker driven without both visibilities");
	AST_QUARTER: assert property (@(posedge sys_clk) disable iff (rst)
		sAcceptPlain |-> !cpuReady [*4] ##1 cpuReady)
		else $error("bus cycle not four clocks");
	AST_STRETCH: assert property (@(posedge sys_clk) disable iff (rst)
		sAcceptStr |-> ##STR_DLY cpuReady)
		else $error("stretched cycle wrong length");
	AST_KBD_GATE: assert property (@(posedge sys_clk) disable iff (rst)
		(!st_r.kScan && !st_r.kFlag) |=> !st_r.kFlag)
		else $error("keyboard flag set while scan disabled");
	AST_IRQ_MASK: assert property (@(posedge sys_clk) disable iff (rst)
		(st_r.iFlag && !st_r.iEn) |-> !irqReq)
		else $error("masked interrupt requested");
	AST_STOP_EN: assert property (@(posedge sys_clk) disable iff (rst)
		stopWaitExec |=> st_r.iEn)
		else $error("stop/wait did not enable interrupt");
	AST_VEC_CLR: assert property (@(posedge sys_clk) disable iff (rst)
		(vectorFetch && !iSet) |=> !st_r.iFlag)
		else $error("vector fetch left flag set");
	AST_ACK_CLR: assert property (@(posedge sys_clk) disable iff (rst)
		(wrEic && wd[`SCEIC_B_IACK] && !st_r.iel && !iSet) |=> !st_r.iFlag)
		else $error("ack did not clear edge flag");
	AST_MODE_LATCH: assert property (@(posedge sys_clk) disable iff (rst)
		st_r.inReset |=> busMuxed == $past(modeIn))
		else $error("bus mode not caught at release");
endmodule // sys_config_ext_int_ctrl

// ### verification/sceic_ext_mem.sv
`timescale 1ns/1ps
// ==========================================
// board and external memory on the expanded bus
module sceic_ext_mem #(
	parameter logic MODE_LEVEL = 1'b0
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire sceic_pkg::sceic_ext_t extBus,
	output logic [7:0] adIn,
	output logic modeIn,
	output logic [7:0] lastWr
);
	logic relDone_r;
	logic [7:0] lastAd_r;
	// strap held through reset and its release edge, then let go
	always @(posedge sys_clk) begin
		relDone_r <= !rst;
		if (rst || !relDone_r) begin
			modeIn <= MODE_LEVEL;
		end else begin
			modeIn <= !modeIn; // no pull on the pin
		end
	end
	// read data only while the read strobe is low; released lines wander so stale data is not trusted
	assign adIn = !extBus.rdN ? (extBus.addrLo ^ 8'h5a) : ~lastAd_r;
	// capture what the device writes on the data lines
	always @(posedge sys_clk) begin
		lastAd_r <= adIn;
		if (!extBus.wrN) begin
			lastWr <= extBus.adOut;
		end
	end
endmodule // sceic_ext_mem

// ### verification/tb_sys_config_ext_int_ctrl.sv
`timescale 1ns/1ps
module tb_sys_config_ext_int_ctrl;
	localparam int STR = 2;
	localparam logic [11:0] A_CFG = 12'h040;
	localparam logic [11:0] A_EIC = 12'h068;
	localparam logic [11:0] A_MODE = 12'h044;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	sceic_pkg::sceic_apb_req_t apb = '0;
	sceic_pkg::sceic_cpu_req_t cpu = '0;
	sceic_pkg::sceic_ext_t ext;
	logic [31:0] prdata;
	logic pready, pslverr, cpuReady, vectorFetch = 1'b0, stopWaitExec = 1'b0, extIntN = 1'b1;
	logic [7:0] cpuRdata, adIn, lastWr, portDIn = 8'hff;
	logic modeIn, modeOeN, selectOneIsPort, irqReq, kbdIrqReq, wdEn, lowVoltEn, busMuxed;
	int numErrors = 0;
	int totalChecks = 0;
	// ==========================================
	// clock and parts
	always #2 sys_clk = ~sys_clk;
	sys_config_ext_int_ctrl #(.STRETCH_CYC(STR)) sys_config_ext_int_ctrl_inst (.sys_clk(sys_clk),
		.rst(rst), .apbReq(apb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cpuReq(cpu), .cpuReady(cpuReady), .cpuRdata(cpuRdata), .vectorFetch(vectorFetch),
		.stopWaitExec(stopWaitExec), .extBus(ext), .adIn(adIn), .modeIn(modeIn), .modeOut(),
		.modeOeN(modeOeN), .extIntN(extIntN), .portDIn(portDIn), .portDDir(8'h00),
		.selectOneIsPort(selectOneIsPort), .irqReq(irqReq), .kbdIrqReq(kbdIrqReq), .wakeReq(),
		.watchdogEnable(wdEn), .lowVoltageResetEnable(lowVoltEn), .busMuxed(busMuxed));
	sceic_ext_mem #(.MODE_LEVEL(1'b0)) sceic_ext_mem_inst (.sys_clk(sys_clk), .rst(rst),
		.extBus(ext), .adIn(adIn), .modeIn(modeIn), .lastWr(lastWr));
	// ==========================================
	// common tasks
	task automatic end_of_test();
		$display("checks %0d errors %0d", totalChecks, numErrors);
		if (numErrors == 0 && totalChecks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		totalChecks++;
		if (got !== exp) begin
			numErrors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	// apb transfer; request held until pready is sampled high
	task automatic apb_xfer(input logic wr, input logic [11:0] a, input logic [7:0] d,
		output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		@(posedge sys_clk);
		apb <= '{psel:1'b1, penable:1'b0, pwrite:wr, paddr:a, pwdata:{24'h0, d}};
		@(posedge sys_clk);
		apb.penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		apb.psel <= 1'b0;
		apb.penable <= 1'b0;
		// one idle edge so the write is visible to the caller's checks
		@(posedge sys_clk);
		if (n >= 20) begin
			numErrors++;
			end_of_test();
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [31:0] r;
		logic e;
		apb_xfer(1'b1, a, d, r, e);
	endtask
	task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic e;
		apb_xfer(1'b0, a, 8'h00, r, e);
		chk(what, exp, r);
	endtask
	// cpu access: counts edges from the accepting edge up to the ready cycle
	task automatic cpu_acc(input logic w, input logic intl, input logic [15:0] a,
		input logic [7:0] d, output int n, output logic sawRd);
		n = 0;
		sawRd = 1'b0;
		@(posedge sys_clk);
		cpu <= '{valid:1'b1, write:w, internalAcc:intl, fetch:1'b0, addr:a, wdata:d};
		do begin
			@(posedge sys_clk);
			#1;
			n++;
			if (ext.rdN === 1'b0) sawRd = 1'b1;
		end while (cpuReady !== 1'b1 && n < 40);
		@(posedge sys_clk);
		cpu.valid <= 1'b0;
		#1;
		if (n >= 40) begin
			numErrors++;
			end_of_test();
		end
	endtask
	task automatic pulse(input bit vec);
		@(posedge sys_clk);
		if (vec) begin
			vectorFetch <= 1'b1;
		end else begin
			stopWaitExec <= 1'b1;
		end
		@(posedge sys_clk);
		vectorFetch <= 1'b0;
		stopWaitExec <= 1'b0;
		repeat (2) @(posedge sys_clk);
	endtask
	// ==========================================
	// scenarios
	task automatic test_reset();
		logic [31:0] r;
		logic e;
		rd_chk("ctrl status", A_EIC, 32'h04);
		rd_chk("cfg", A_CFG, 32'h30);
		rd_chk("mode", A_MODE, 32'h0);
		chk("isPort", 1, selectOneIsPort);
		apb_xfer(1'b0, 12'h07c, 8'h00, r, e);
		chk("unmapped err", 1, e);
		chk("unmapped data", 0, r);
		$display("test_reset done");
	endtask
	task automatic test_cfg();
		wr(A_CFG, 8'h39);
		chk("wd on", 1, wdEn);
		chk("low volt on", 1, lowVoltEn);
		wr(A_CFG, 8'h10);
		chk("wd locked", 1, wdEn);
		chk("low volt off", 0, lowVoltEn);
		chk("not port", 0, selectOneIsPort);
		rd_chk("cfg", A_CFG, 32'h11);
		wr(A_CFG, 8'h14);
		chk("marker off", 1, modeOeN);
		wr(A_CFG, 8'h16);
		chk("marker on", 0, modeOeN);
		$display("test_cfg done");
	endtask
	task automatic test_bus();
		int n;
		logic s;
		wr(A_CFG, 8'h11);
		cpu_acc(1'b0, 1'b0, 16'h0040, 8'h00, n, s);
		chk("ext rd", 1, s);
		chk("ext len", 4, n);
		chk("rdata", 8'h1a, cpuRdata);
		cpu_acc(1'b0, 1'b0, 16'h0035, 8'h00, n, s);
		chk("stretch len", STR + 3, n);
		cpu_acc(1'b1, 1'b0, 16'h4123, 8'ha6, n, s);
		chk("wdata", 8'ha6, lastWr);
		cpu_acc(1'b0, 1'b1, 16'h1200, 8'h00, n, s);
		chk("hidden rd", 0, s);
		chk("hidden len", 4, n);
		chk("held addr", 8'h41, ext.addrHi);
		wr(A_CFG, 8'h13);
		cpu_acc(1'b0, 1'b1, 16'h1200, 8'h00, n, s);
		chk("visible rd", 1, s);
		$display("test_bus done");
	endtask
	task automatic test_ext_int();
		wr(A_EIC, 8'h00);
		extIntN <= 1'b0;
		repeat (3) @(posedge sys_clk);
		rd_chk("flag set", A_EIC, 32'h08);
		chk("masked", 0, irqReq);
		wr(A_EIC, 8'h03);
		rd_chk("acked", A_EIC, 32'h00);
		extIntN <= 1'b1;
		repeat (3) @(posedge sys_clk);
		extIntN <= 1'b0;
		repeat (3) @(posedge sys_clk);
		pulse(1'b0);
		chk("forced en", 1, irqReq);
		pulse(1'b1);
		chk("vector clr", 0, irqReq);
		rd_chk("after vec", A_EIC, 32'h04);
		extIntN <= 1'b1;
		$display("test_ext_int done");
	endtask
	task automatic test_kbd();
		portDIn <= 8'hfe;
		repeat (3) @(posedge sys_clk);
		rd_chk("scan off", A_EIC, 32'h04);
		portDIn <= 8'hff;
		wr(A_EIC, 8'h44);
		portDIn <= 8'h7f;
		repeat (3) @(posedge sys_clk);
		rd_chk("kbd flag", A_EIC, 32'hc4);
		chk("kbd irq", 1, kbdIrqReq);
		wr(A_EIC, 8'h64);
		rd_chk("kbd ack", A_EIC, 32'h44);
		wr(A_EIC, 8'h94);
		rd_chk("kbd lock", A_EIC, 32'h04);
		$display("test_kbd done");
	endtask
	// ==========================================
	// main sequence
	initial begin
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (2) @(posedge sys_clk);
		test_reset();
		test_cfg();
		test_bus();
		test_ext_int();
		test_kbd();
		end_of_test();
	end
endmodule // tb_sys_config_ext_int_ctrl
